// ===== dpram_pkg.sv
// shared constants and carrier types for the dual-port synchronous ram
package dpram_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_MAX = 18;
  localparam int ADDR_DEFAULT = 16;
  localparam int DATA_W = 72;
  localparam int LANES = 8;
  localparam int LANE_W = 9;
  localparam int NUM_PORTS = 2;

  // ==========================================================
  // values after reset
  localparam logic [17:0] MASK_RESET = 18'h3_ffff;
  localparam logic [17:0] ADDR_RESET = 18'h0_0000;
  localparam logic PDOWN_RESET = 1'b1;

  // ==========================================================
  // carriers
  // one port's pins as seen from inside, sampled every clock
  typedef struct packed {
    logic chip_select_low_active_n;
    logic chip_select_high_active;
    logic write_en;
    logic addr_load;
    logic cnt_advance;
    logic cnt_restart;
    logic mask_load;
    logic cnt_readback;
    logic mask_readback;
    logic mbox_send;
    logic mbox_clear;
    logic [LANES-1:0] byte_lane_enable;
    logic [ADDR_MAX-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } port_in_t;

  // one port's driven pins and flags
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic data_oe;
    logic [ADDR_MAX-1:0] addr_out;
    logic addr_oe;
    logic counter_wrap_flag;
    logic mbox_flag;
    logic powered_down;
  } port_out_t;

  localparam port_in_t IN_RESET = '0;
  localparam port_out_t OUT_RESET = '0;

endpackage : dpram_pkg

// ===== dual_port_sync_ram_ports.sv
// dual-port pipelined ram with burst counters, masks and mailboxes
`timescale 1ns/1ps
module dual_port_sync_ram_ports #(
  parameter int ADDR_W = dpram_pkg::ADDR_DEFAULT
) (
  // clock and global clear
  input wire logic clock_in,
  input wire logic nrst_in,
  // port pins, index 0 left and 1 right
  input wire dpram_pkg::port_in_t port_in [2],
  output dpram_pkg::port_out_t port_out [2]
);
  import dpram_pkg::*;

  // ==========================================================
  // storage and shared state
  localparam int DEPTH = 2 ** ADDR_W;
  localparam logic [17:0] AMASK = 18'((32'd1 << ADDR_W) - 32'd1);

  logic [DATA_W-1:0] mem [DEPTH];
  port_in_t in_reg [2];
  port_out_t out_reg [2];
  port_out_t out_next [2];
  logic [17:0] cnt_reg [2];
  logic [17:0] cnt_next [2];
  logic [17:0] mask_reg [2];
  logic [17:0] mask_next [2];
  logic [17:0] start_reg [2];
  logic [17:0] start_next [2];
  logic [1:0] pd_reg;
  logic [1:0] pd_next;
  logic [1:0] en;
  logic [1:0] active;
  logic [1:0] wrap;
  logic [1:0] wr_stb;
  logic [17:0] eff [2];
  logic [17:0] inc [2];
  logic [17:0] mval [2];

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  // only the three documented depths are legal; any other width stops
  // elaboration here instead of building a ram of the wrong size
  if (ADDR_W < ADDR_DEFAULT || ADDR_W > ADDR_MAX)
  begin : g_bad_width
    $error("address width must be 16, 17 or 18 bits");
  end

  assign port_out = out_reg;

  // ==========================================================
  // per-port datapath, both ports identical, coupled only through the array and the mailbox flag
  // both ports share clock_in here, so unrelated port clocks are not built
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    localparam int Q = 1 - p;

    // selection and the counter arithmetic for this cycle
    always_comb
    begin
      en[p] = !in_reg[p].chip_select_low_active_n &&
              in_reg[p].chip_select_high_active;
      // a first selected cycle after power-down re-arms; counter, mask and mailbox still act, but no output or write
      active[p] = en[p] && !pd_reg[p];
      mval[p] = mask_reg[p] & AMASK;
      eff[p] = in_reg[p].addr_load ? (in_reg[p].addr & AMASK)
                                   : cnt_reg[p];
      // masked bits count, unmasked bits stay put; unmasked bits are
      // forced to one so the carry jumps over them to the next field bit
      inc[p] = (eff[p] & ~mval[p]) |
               (18'((eff[p] | ~mval[p]) + 18'h0_0001) & mval[p]);
      wrap[p] = en[p] && in_reg[p].cnt_advance &&
                !in_reg[p].cnt_restart && !in_reg[p].mask_load &&
                ((eff[p] & mval[p]) == mval[p]);
      // strobe is high in every active cycle in which the write pin was sampled high and no mask load or readback was requested
      wr_stb[p] = active[p] && in_reg[p].write_en &&
                  !in_reg[p].mask_load && !in_reg[p].cnt_readback &&
                  !in_reg[p].mask_readback;
    end

    // counter, mask and retransmit start address
    always_comb
    begin
      cnt_next[p] = cnt_reg[p];
      mask_next[p] = mask_reg[p];
      start_next[p] = start_reg[p];
      if (en[p])
      begin
        if (in_reg[p].mask_load)
        begin
          mask_next[p] = in_reg[p].addr & AMASK;
        end
        else
        begin
          if (in_reg[p].addr_load)
          begin
            start_next[p] = in_reg[p].addr & AMASK;
          end
          if (in_reg[p].cnt_restart)
          begin
            cnt_next[p] = start_reg[p];
          end
          else if (in_reg[p].cnt_advance)
          begin
            cnt_next[p] = inc[p];
          end
          else if (in_reg[p].addr_load)
          begin
            cnt_next[p] = eff[p];
          end
        end
      end
      pd_next[p] = !en[p];
    end

    // output register: read data, readback and flags
    always_comb
    begin
      out_next[p] = out_reg[p];
      out_next[p].data_oe = active[p] && !in_reg[p].write_en &&
                            !in_reg[p].mask_load &&
                            !in_reg[p].cnt_readback &&
                            !in_reg[p].mask_readback;
      if (out_next[p].data_oe)
      begin
        out_next[p].rdata = mem[eff[p][ADDR_W-1:0]];
      end
      out_next[p].addr_oe = active[p] &&
                            (in_reg[p].cnt_readback ||
                             in_reg[p].mask_readback);
      if (in_reg[p].cnt_readback)
      begin
        out_next[p].addr_out = cnt_reg[p];
      end
      else if (in_reg[p].mask_readback)
      begin
        out_next[p].addr_out = mask_reg[p];
      end
      // a new load or restart clears the wrap flag; a wrap wins
      if (wrap[p])
      begin
        out_next[p].counter_wrap_flag = 1'b1;
      end
      else if (en[p] && (in_reg[p].addr_load || in_reg[p].cnt_restart))
      begin
        out_next[p].counter_wrap_flag = 1'b0;
      end
      // the far port sets this flag; a send wins over our clear
      if (en[Q] && in_reg[Q].mbox_send)
      begin
        out_next[p].mbox_flag = 1'b1;
      end
      else if (en[p] && in_reg[p].mbox_clear)
      begin
        out_next[p].mbox_flag = 1'b0;
      end
      out_next[p].powered_down = pd_next[p];
    end

    // pipeline and state registers for this port
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        in_reg[p] <= IN_RESET;
        out_reg[p] <= OUT_RESET;
        cnt_reg[p] <= ADDR_RESET;
        mask_reg[p] <= MASK_RESET & AMASK;
        start_reg[p] <= ADDR_RESET;
        pd_reg[p] <= PDOWN_RESET;
      end
      else
      begin
        in_reg[p] <= port_in[p];
        out_reg[p] <= out_next[p];
        cnt_reg[p] <= cnt_next[p];
        mask_reg[p] <= mask_next[p];
        start_reg[p] <= start_next[p];
        pd_reg[p] <= pd_next[p];
      end
    end

    // ========================================================
    // checks for this port
    property p_pd_outputs_off;
      !en[p] |=> !port_out[p].data_oe && !port_out[p].addr_oe;
    endproperty
    a_pd_outputs_off: assert property (p_pd_outputs_off)
      else $error("outputs driven after a deselected cycle");

    property p_reenable;
      en[p] && pd_reg[p] |=> !port_out[p].data_oe &&
                             !port_out[p].addr_oe ##0 !pd_reg[p];
    endproperty
    a_reenable: assert property (p_reenable)
      else $error("outputs came back without a re-arm cycle");

    property p_read_latency;
      active[p] && !in_reg[p].write_en && !in_reg[p].mask_load &&
      !in_reg[p].cnt_readback && !in_reg[p].mask_readback
      |=> port_out[p].data_oe;
    endproperty
    a_read_latency: assert property (p_read_latency)
      else $error("read data not presented one edge after capture");

    property p_readback_cnt;
      active[p] && in_reg[p].cnt_readback
      |=> port_out[p].addr_oe && port_out[p].addr_out == $past(cnt_reg[p]);
    endproperty
    a_readback_cnt: assert property (p_readback_cnt)
      else $error("counter readback wrong");

    property p_readback_mask;
      active[p] && in_reg[p].mask_readback && !in_reg[p].cnt_readback
      |=> port_out[p].addr_out == $past(mask_reg[p]);
    endproperty
    a_readback_mask: assert property (p_readback_mask)
      else $error("mask readback wrong");

    property p_wrap_flag;
      wrap[p] |=> port_out[p].counter_wrap_flag && cnt_reg[p] ==
                  ($past(eff[p]) & ~$past(mval[p]));
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)
      else $error("wrap did not set flag or clear masked bits");

    property p_retransmit;
      en[p] && in_reg[p].cnt_restart && !in_reg[p].mask_load
      |=> cnt_reg[p] == $past(start_reg[p]);
    endproperty
    a_retransmit: assert property (p_retransmit)
      else $error("retransmit did not restore start address");

    property p_mbox;
      en[Q] && in_reg[Q].mbox_send |=> port_out[p].mbox_flag;
    endproperty
    a_mbox: assert property (p_mbox)
      else $error("mailbox flag not raised by far port");

    property p_advance_held;
      en[p] && in_reg[p].cnt_advance && !in_reg[p].cnt_restart &&
      !in_reg[p].mask_load
      |=> (cnt_reg[p] & ~$past(mval[p])) ==
          ($past(eff[p]) & ~$past(mval[p]));
    endproperty
    a_advance_held: assert property (p_advance_held)
      else $error("unmasked counter bits changed");

    property p_pdown_flag;
      !en[p] |=> port_out[p].powered_down;
    endproperty
    a_pdown_flag: assert property (p_pdown_flag)
      else $error("power-down flag missing after a deselected cycle");

    property p_counter_frozen;
      !en[p] |=> cnt_reg[p] == $past(cnt_reg[p]);
    endproperty
    a_counter_frozen: assert property (p_counter_frozen)
      else $error("counter moved while the port was deselected");

    property p_wrap_rise;
      $rose(port_out[p].counter_wrap_flag) |-> $past(wrap[p]);
    endproperty
    a_wrap_rise: assert property (p_wrap_rise)
      else $error("wrap flag rose without a counter wrap");

    property p_wrap_clear;
      en[p] && (in_reg[p].addr_load || in_reg[p].cnt_restart) && !wrap[p]
      |=> !port_out[p].counter_wrap_flag;
    endproperty
    a_wrap_clear: assert property (p_wrap_clear)
      else $error("wrap flag not cleared by a load or restart");

    property p_mbox_clear;
      en[p] && in_reg[p].mbox_clear && !(en[Q] && in_reg[Q].mbox_send)
      |=> !port_out[p].mbox_flag;
    endproperty
    a_mbox_clear: assert property (p_mbox_clear)
      else $error("mailbox flag not cleared by own port");

    property p_readback_oe;
      active[p] && (in_reg[p].cnt_readback || in_reg[p].mask_readback)
      |=> port_out[p].addr_oe && !port_out[p].data_oe;
    endproperty
    a_readback_oe: assert property (p_readback_oe)
      else $error("readback did not take the address lines alone");

    property p_rdata_holds;
      !port_out[p].data_oe |-> $stable(port_out[p].rdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
      else $error("read data changed without a read");

    c_wrap: cover property (wrap[p] ##1 port_out[p].counter_wrap_flag);
    c_readback: cover property (port_out[p].addr_oe);
    c_mbox: cover property (port_out[p].mbox_flag ##1 !port_out[p].mbox_flag);
    c_pd_cycle: cover property (!en[p] ##1 en[p] ##1 active[p]);
    c_restart: cover property (en[p] && in_reg[p].cnt_restart);
  end

  // ==========================================================
  // array write; both ports may hit the same word in one cycle
  // and the higher port wins, which is fine since that case is
  // left undefined for the masters
  always_ff @(posedge clock_in)
  begin : mem_write
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (wr_stb[p])
      begin
        for (int l = 0; l < LANES; l++)
        begin
          if (in_reg[p].byte_lane_enable[l])
          begin
            mem[eff[p][ADDR_W-1:0]][l*LANE_W +: LANE_W] <=
              in_reg[p].wdata[l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

endmodule : dual_port_sync_ram_ports

// ===== port_master.sv
// bus master model that drives one port of the dual-port ram
`timescale 1ns/1ps
module port_master
  import dpram_pkg::*;
(
  // clock
  input wire logic clock_in,
  // pins into the ram
  output dpram_pkg::port_in_t pin_out
);
  // ==========================================================
  // request driver
  localparam port_in_t SEL = '{chip_select_high_active: 1'b1, default: '0};

  // idle selected, so the ram re-arms right after reset
  initial pin_out = SEL;

  // one request for one cycle, then no operation; the high-active select is kept so a
  // deselect stands until the next request (one full selected cycle
  // is then spent re-arming); released data lines are inverted
  task automatic req(input port_in_t v);
    port_in_t t;
    @(negedge clock_in);
    pin_out = v;
    t = SEL;
    t.chip_select_high_active = v.chip_select_high_active;
    t.addr = ~v.addr;
    t.wdata = ~v.wdata;
    @(negedge clock_in);
    pin_out = t;
  endtask : req
endmodule : port_master

// ===== testbench.sv
// self-checking testbench for the dual-port ram
`timescale 1ns/1ps
module testbench;
  import dpram_pkg::*;
  // ==========================================================
  // signals and instances
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  port_in_t pins [2];
  port_out_t po [2];
  int n_mismatch = 0;
  int compares = 0;
  localparam logic [8:0] WE = 9'h100, AL = 9'h080, ADV = 9'h040;
  localparam logic [8:0] RS = 9'h020, ML = 9'h010, CRB = 9'h008;
  localparam logic [8:0] MRB = 9'h004, MS = 9'h002, MC = 9'h001;
  localparam logic [71:0] D1 = {8{9'h0a5}};
  localparam logic [71:0] D2 = {8{9'h15a}};

  dual_port_sync_ram_ports dual_port_sync_ram_ports_i (
    .clock_in(clock_in), .nrst_in(nrst_in), .port_in(pins), .port_out(po));
  port_master port_master_l_i (.clock_in(clock_in), .pin_out(pins[0]));
  port_master port_master_r_i (.clock_in(clock_in), .pin_out(pins[1]));

  // 200 MHz clock
  always #2.5 clock_in = ~clock_in;

  // ==========================================================
  // access and compare tasks
  // one request, then wait until its answer stands at a falling edge
  task automatic op(input int p, input logic [8:0] f,
    input logic [17:0] a, input logic [71:0] d = '0,
    input logic [7:0] be = 8'hff, input logic sel = 1'b1);
    port_in_t v;
    v = port_in_t'({1'b0, sel, f, be, a, d});
    if (p == 0)
      port_master_l_i.req(v);
    else
      port_master_r_i.req(v);
    @(negedge clock_in);
  endtask : op

  task automatic chk(input string nm, input logic [71:0] e,
    input logic [71:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // test sequence; masters never write one word from both ports
  initial
  begin
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clock_in);
    // written on one port, read on the other
    op(0, WE | AL, 18'h0_0010, D1);
    op(1, AL, 18'h0_0010);
    chk("read oe", 1'b1, po[1].data_oe);
    chk("cross read", D1, po[1].rdata);
    // lanes 0 to 3 only
    op(0, WE | AL, 18'h0_0010, D2, 8'h0f);
    fork
      op(0, AL, 18'h0_0010);
      op(1, AL, 18'h0_0010);
    join
    chk("lanes l", {D1[71:36], D2[35:0]}, po[0].rdata);
    chk("same cycle r", {D1[71:36], D2[35:0]}, po[1].rdata);
    // mask of two bits, burst of two writes that wraps
    op(0, ML, 18'h0_0003);
    op(0, MRB, 18'h0_0000);
    chk("mask back", 18'h0_0003, po[0].addr_out);
    op(0, WE | AL | ADV, 18'h0_0022, D1);
    op(0, WE | ADV, 18'h0_0000, D2);
    chk("wrap flag", 1'b1, po[0].counter_wrap_flag);
    op(0, CRB, 18'h0_0000);
    chk("cnt back", 18'h0_0020, po[0].addr_out);
    chk("back oe", 1'b1, po[0].addr_oe);
    op(0, RS, 18'h0_0000);
    chk("flag clr", 1'b0, po[0].counter_wrap_flag);
    op(0, CRB, 18'h0_0000);
    chk("restart", 18'h0_0022, po[0].addr_out);
    op(1, AL, 18'h0_0023);
    chk("burst word", D2, po[1].rdata);
    // power down, re-arm cycle, then normal read
    op(1, 9'h000, 18'h0_0000, '0, 8'hff, 1'b0);
    chk("pdown", 1'b1, po[1].powered_down);
    op(1, AL, 18'h0_0022);
    chk("rearm oe", 1'b0, po[1].data_oe);
    op(1, AL, 18'h0_0022);
    chk("after rearm", D1, po[1].rdata);
    // mailbox from left to right, cleared by right
    op(0, MS, 18'h0_0000);
    chk("mbox set", 1'b1, po[1].mbox_flag);
    op(1, MC, 18'h0_0000);
    chk("mbox clr", 1'b0, po[1].mbox_flag);
    op(0, MS, 18'h0_0000);
    // clear between edges must act at once
    nrst_in = 1'b0;
    #1;
    chk("async clr", 1'b0, po[1].mbox_flag);
    report_and_stop();
  end

  // watchdog, far beyond the roughly 65 cycles the tests need
  initial
  begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : testbench
